/* File: hdl/lid_pkg.sv */
// package of constants and types for the lcd instruction decoder
package lid_pkg;
    // ------------------------------------------------------------
    // bus operations and instruction codes
    // ------------------------------------------------------------
    localparam logic [7:0] SPACE_CODE     = 8'h20;
    localparam logic [6:0] AC_ORIGIN      = 7'h00;
    localparam logic [7:0] OP_STANDBY     = 8'h01;
    // ------------------------------------------------------------
    // timing: clock rate and execution times
    // ------------------------------------------------------------
    localparam int CLK_HZ      = 25_000_000;
    localparam int T_CLEAR_US  = 1600;
    localparam int T_INSTR_US  = 72;
    localparam int CYC_CLEAR   = T_CLEAR_US * (CLK_HZ / 1_000_000);
    localparam int CYC_INSTR   = T_INSTR_US * (CLK_HZ / 1_000_000);
    localparam int CNT_W       = 16;
    // ------------------------------------------------------------
    // memory sizes and reset values
    // ------------------------------------------------------------
    localparam int CHAR_WORDS  = 64;
    localparam int FONT_WORDS  = 64;
    localparam int ICON_WORDS  = 16;
    localparam int GFX_WORDS   = 2048;
    localparam logic [3:0] ICON_UNUSED = 4'hF;
    localparam logic [1:0] LINE_SEL_RST = 2'h0;
    // ------------------------------------------------------------
    // target memory of the address counter
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        LID_TGT_CHAR = 2'h0,
        LID_TGT_FONT = 2'h1,
        LID_TGT_ICON = 2'h3,
        LID_TGT_GFX  = 2'h2
    } lid_tgt_t;
    // execution states, gray along idle-busy-clear
    typedef enum logic [1:0] {
        LID_IDLE  = 2'h0,
        LID_BUSY  = 2'h1,
        LID_CLEAR = 2'h3
    } lid_state_t;
endpackage : lid_pkg

/* File: hdl/lid_decoder.sv */
// instruction decoder of a dot-matrix lcd controller
//
// Implementation choices: strobed register access and the register offsets.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - clear fills char memory with 20H, counter 00H, increment, 1.6 ms
// - home loads counter 00H, memory untouched, 72 us
// - entry direction 1 increments, 0 decrements after each ram access except graphic writes, which always increment
// - shift instruction moves cursor or shifts display, memory untouched
// - extended-set select persists until changed
// - user-font address loads six bits, only when scroll select is 0
// - char address loads low bits, top address bit held 0
// - status read gives busy on bit 7, counter on bits 6..0
// - data write goes to memory that counter targets, 72 us
// - data read returns addressed memory byte, 72 us
// - extended 01H enters standby, any later instruction ends it
// - scroll select stores its low bit
// - reverse toggles one of four lines, field starts 00
// - sleep bit 0 enters sleep, 1 leaves it
// - extended function set holds graphic enable in bit 1
// - icon/scroll address: six scroll bits or four icon bits
// - graphic address: vertical then horizontal write
// - icon memory sixteen 16-bit words, address 15 unused
// - font row sixteen is ORed with cursor pattern
// - char code bits 1,2 give font address bits 4,5
// - reset defaults as listed
// - select and read lines decode four operations
// - instructions ignored while busy
// - 16-bit words written high byte first, counter steps after second
// - first data read after address set is a dummy
module lid_decoder
(
    input  wire logic                 clock,
    input  wire logic                 rst,
    input  wire logic                 strobe,
    input  wire logic                 reg_sel,
    input  wire logic                 read_not_write,
    input  wire logic [7:0]           wr_data,
    output logic      [7:0]           rd_data,
    output logic                      busy_flag,
    output logic                      display_on,
    output logic                      cursor_on,
    output logic                      blink_on,
    output logic                      bus_width,
    output logic                      ext_set_sel,
    output logic                      scroll_sel,
    output logic                      graphic_on,
    output logic                      awake_bit,
    output logic                      standby,
    output logic      [3:0]           line_reversed,
    output logic      [5:0]           scroll_offset,
    output logic      [4:0]           shift_pos,
    output logic      [15:0]          font_row_out,
    input  wire logic [5:0]           font_row_addr,
    input  wire logic [15:0]          cursor_pattern,
    input  wire logic [15:0]          char_code,
    output logic      [15:0]          icon_word,
    input  wire logic [3:0]           icon_addr
);
    import lid_pkg::*;

    // ------------------------------------------------------------
    // state record
    // ------------------------------------------------------------
    typedef struct packed {
        lid_state_t       st;
        logic [CNT_W-1:0] cnt;
        logic [6:0]       ac;
        lid_tgt_t         tgt;
        logic [6:0]       gfx_v;
        logic             gfx_wait_h;
        logic             inc;
        logic             shift_en;
        logic             disp;
        logic             cur;
        logic             blk;
        logic             dl;
        logic             re;
        logic             sr;
        logic             g;
        logic             awake;
        logic             stby;
        logic [3:0]       rev;
        logic [5:0]       scroll;
        logic [4:0]       shift;
        logic             hi_done;
        logic [7:0]       hi_byte;
        logic             dummy;
        logic             rd_lo;
        logic [7:0]       rd;
        logic [5:0]       clr_idx;
    } lid_regs_t;

    lid_regs_t s_reg;
    lid_regs_t s_next;

    // memories are written from the clocked process only
    logic [15:0] char_mem      [CHAR_WORDS];
    logic [15:0] user_font_mem [FONT_WORDS];
    logic [15:0] icon_mem      [ICON_WORDS];
    logic [15:0] graphic_mem   [GFX_WORDS];

    logic        mem_we;
    logic [15:0] mem_wdata;
    logic        clr_we;
    logic [15:0] rd_word;
    logic [10:0] gfx_index;

    // step counter in the selected direction
    function automatic logic [6:0] ac_step(input logic [6:0] a,
                                           input logic d);
        ac_step = d ? 7'(a + 7'h01) : 7'(a - 7'h01);
    endfunction : ac_step

    // ------------------------------------------------------------
    // read side
    // ------------------------------------------------------------
    // graphic address: vertical row, horizontal word in low four bits
    assign gfx_index = {s_reg.gfx_v, s_reg.ac[3:0]};

    // word at the address counter, per target
    always_comb
    begin
        case (s_reg.tgt)
            LID_TGT_CHAR: rd_word = char_mem[s_reg.ac[5:0]];
            LID_TGT_FONT: rd_word = user_font_mem[s_reg.ac[5:0]];
            LID_TGT_ICON: rd_word = icon_mem[s_reg.ac[3:0]];
            LID_TGT_GFX:  rd_word = graphic_mem[gfx_index];
            default:      rd_word = 16'h0000;
        endcase
    end

    // ------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------
    // one instruction or data byte taken per strobe when not busy
    always_comb
    begin
        s_next    = s_reg;
        mem_we    = 1'b0;
        clr_we    = 1'b0;
        mem_wdata = {s_reg.hi_byte, wr_data};
        case (s_reg.st)
            LID_IDLE:
            begin
                if (strobe && reg_sel && !read_not_write)
                begin
                    // data write, pair high then low
                    s_next.st  = LID_BUSY;
                    s_next.cnt = CNT_W'(CYC_INSTR - 1);
                    if (!s_reg.hi_done)
                    begin
                        s_next.hi_byte = wr_data;
                        s_next.hi_done = 1'b1;
                    end
                    else
                    begin
                        s_next.hi_done = 1'b0;
                        mem_we         = !(s_reg.tgt == LID_TGT_ICON
                                           && s_reg.ac[3:0] == ICON_UNUSED);
                        if (s_reg.tgt == LID_TGT_GFX) // horizontal wraps
                            s_next.ac = {3'h0, 4'(s_reg.ac[3:0] + 4'h1)};
                        else
                            s_next.ac = ac_step(s_reg.ac, s_reg.inc);
                    end
                end
                else if (strobe && reg_sel && read_not_write)
                begin
                    s_next.st  = LID_BUSY;
                    s_next.cnt = CNT_W'(CYC_INSTR - 1);
                    if (s_reg.dummy)
                        s_next.dummy = 1'b0;
                    else
                    begin
                        s_next.rd    = s_reg.rd_lo ? rd_word[7:0]
                                                   : rd_word[15:8];
                        s_next.rd_lo = !s_reg.rd_lo;
                        if (s_reg.rd_lo)
                            s_next.ac = ac_step(s_reg.ac, s_reg.inc);
                    end
                end
                else if (strobe && !reg_sel && read_not_write)
                begin
                    s_next.rd = {s_reg.st != LID_IDLE, s_reg.ac};
                end
                else if (strobe && !reg_sel)
                begin
                    s_next.st      = LID_BUSY;
                    s_next.cnt     = CNT_W'(CYC_INSTR - 1);
                    s_next.stby    = 1'b0;
                    s_next.hi_done = 1'b0;
                    if (wr_data[7])
                    begin
                        s_next.dummy = 1'b1;
                        s_next.rd_lo = 1'b0;
                        if (s_reg.re && s_reg.gfx_wait_h)
                        begin
                            s_next.ac         = {3'h0, wr_data[3:0]};
                            s_next.tgt        = LID_TGT_GFX;
                            s_next.gfx_wait_h = 1'b0;
                        end
                        else if (s_reg.re)
                        begin
                            s_next.gfx_v      = wr_data[6:0];
                            s_next.gfx_wait_h = 1'b1;
                        end
                        else
                        begin
                            s_next.ac  = {1'b0, wr_data[5:0]};
                            s_next.tgt = LID_TGT_CHAR;
                        end
                    end
                    else if (wr_data[6])
                    begin
                        s_next.dummy = 1'b1;
                        s_next.rd_lo = 1'b0;
                        if (s_reg.re && s_reg.sr)
                            s_next.scroll = wr_data[5:0];
                        else if (s_reg.re)
                        begin
                            s_next.ac  = {3'h0, wr_data[3:0]};
                            s_next.tgt = LID_TGT_ICON;
                        end
                        else if (!s_reg.sr)
                        begin
                            s_next.ac  = {1'b0, wr_data[5:0]};
                            s_next.tgt = LID_TGT_FONT;
                        end
                    end
                    else if (wr_data[5])
                    begin
                        s_next.dl = wr_data[4];
                        s_next.re = wr_data[2];
                        if (s_reg.re)
                            s_next.g = wr_data[1];
                    end
                    else if (s_reg.re)
                    begin
                        // extended set
                        if (wr_data[3])
                            s_next.awake = wr_data[2];
                        else if (wr_data[2])
                            s_next.rev[wr_data[1:0]] =
                                !s_reg.rev[wr_data[1:0]];
                        else if (wr_data[1])
                            s_next.sr = wr_data[0];
                        else if (wr_data == OP_STANDBY)
                            s_next.stby = 1'b1;
                    end
                    else if (wr_data[4])
                    begin
                        // cursor or display shift
                        if (!wr_data[3])
                            s_next.ac = ac_step(s_reg.ac, wr_data[2]);
                        else
                            s_next.shift = wr_data[2]
                                ? 5'(s_reg.shift + 5'h01)
                                : 5'(s_reg.shift - 5'h01);
                    end
                    else if (wr_data[3])
                    begin
                        s_next.disp = wr_data[2];
                        s_next.cur  = wr_data[1];
                        s_next.blk  = wr_data[0];
                    end
                    else if (wr_data[2])
                    begin
                        s_next.inc      = wr_data[1];
                        s_next.shift_en = wr_data[0];
                    end
                    else if (wr_data[1])
                    begin
                        s_next.ac  = AC_ORIGIN;
                        s_next.tgt = LID_TGT_CHAR;
                    end
                    else if (wr_data[0])
                    begin
                        s_next.st      = LID_CLEAR;
                        s_next.cnt     = CNT_W'(CYC_CLEAR - 1);
                        s_next.ac      = AC_ORIGIN;
                        s_next.tgt     = LID_TGT_CHAR;
                        s_next.inc     = 1'b1;
                        s_next.clr_idx = 6'h00;
                    end
                end
            end
            LID_BUSY, LID_CLEAR:
            begin
                // new strobes are dropped here, status read still answers
                if (strobe && !reg_sel && read_not_write)
                    s_next.rd = {1'b1, s_reg.ac};
                if (s_reg.st == LID_CLEAR && s_reg.clr_idx != 6'h3F)
                    s_next.clr_idx = 6'(s_reg.clr_idx + 6'h01);
                clr_we = (s_reg.st == LID_CLEAR) && (s_reg.cnt > 0);
                if (s_reg.cnt == '0)
                    s_next.st = LID_IDLE;
                else
                    s_next.cnt = CNT_W'(s_reg.cnt - 1'b1);
            end
            default: s_next.st = LID_IDLE;
        endcase
    end

    // ------------------------------------------------------------
    // registers and memories
    // ------------------------------------------------------------
    // memories carry no reset; clear is the software way to blank char memory
    always_ff @(posedge clock)
    begin
        if (clr_we)
            char_mem[s_reg.clr_idx] <= {SPACE_CODE, SPACE_CODE};
        else if (mem_we)
        begin
            case (s_reg.tgt)
                LID_TGT_CHAR: char_mem[s_reg.ac[5:0]]      <= mem_wdata;
                LID_TGT_FONT: user_font_mem[s_reg.ac[5:0]] <= mem_wdata;
                LID_TGT_ICON: icon_mem[s_reg.ac[3:0]]      <= mem_wdata;
                default:      graphic_mem[gfx_index]       <= mem_wdata;
            endcase
        end
    end

    // state record with reset defaults
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            s_reg       <= '0;
            s_reg.st    <= LID_IDLE;
            s_reg.tgt   <= LID_TGT_CHAR;
            s_reg.inc   <= 1'b1;
            s_reg.dl    <= 1'b1;
            s_reg.awake <= 1'b1;
            s_reg.rev   <= {2'b00, LINE_SEL_RST};
        end
        else
            s_reg <= s_next;
    end

    // ------------------------------------------------------------
    // display-side reads and outputs
    // ------------------------------------------------------------
    // display fetches pass through a register, data outputs stay clean
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            font_row_out <= 16'h0000;
            icon_word    <= 16'h0000;
        end
        else
        begin
            // code bits 1,2 pick the font, low address picks the row
            font_row_out <= user_font_mem[{char_code[2:1],
                                           font_row_addr[3:0]}]
                | ((font_row_addr[3:0] == 4'hF)
                   ? cursor_pattern : 16'h0000);
            icon_word    <= (icon_addr == ICON_UNUSED) ? 16'h0000
                            : icon_mem[icon_addr];
        end
    end

    assign rd_data       = s_reg.rd;
    assign busy_flag     = (s_reg.st != LID_IDLE);
    assign display_on    = s_reg.disp;
    assign cursor_on     = s_reg.cur;
    assign blink_on      = s_reg.blk;
    assign bus_width     = s_reg.dl;
    assign ext_set_sel   = s_reg.re;
    assign scroll_sel    = s_reg.sr;
    assign graphic_on    = s_reg.g;
    assign awake_bit     = s_reg.awake;
    assign standby       = s_reg.stby;
    assign line_reversed = s_reg.rev;
    assign scroll_offset = s_reg.scroll;
    assign shift_pos     = s_reg.shift;
endmodule : lid_decoder
`default_nettype wire

/* File: dv/lid_host.sv */
// host processor model driving the parallel instruction bus
`timescale 1ns/1ps
`default_nettype none
module lid_host
(
    input  wire logic       clock,
    input  wire logic [7:0] rd_data,
    output var logic        strobe,
    output var logic        reg_sel,
    output var logic        read_not_write,
    output var logic [7:0]  wr_data
);
    // ------------------------------------------------------------
    // bus cycles
    // ------------------------------------------------------------
    // bus idle at time zero
    initial
    begin
        strobe = 1'b0;
        reg_sel = 1'b0;
        read_not_write = 1'b0;
        wr_data = 8'h00;
    end

    // one access; released lines show the inverse, never the old value
    task automatic access(input logic rs, input logic rnw,
                          input logic [7:0] d, output logic [7:0] q);
        @(posedge clock);
        strobe         <= 1'b1;
        reg_sel        <= rs;
        read_not_write <= rnw;
        wr_data        <= d;
        @(posedge clock);
        strobe         <= 1'b0;
        reg_sel        <= ~rs;
        read_not_write <= ~rnw;
        wr_data        <= ~d;
        #1 q = rd_data;
    endtask : access

    // poll status until idle; bounded so a stuck flag cannot hang us
    task automatic wait_ready();
        logic [7:0] s;
        s = 8'hFF;
        for (int i = 0; i < 30000 && s[7] !== 1'b0; i++)
            access(1'b0, 1'b1, 8'h00, s);
    endtask : wait_ready

    // every instruction or data byte waits for the busy bit first
    task automatic send(input logic rs, input logic rnw,
                        input logic [7:0] d, output logic [7:0] q);
        wait_ready();
        access(rs, rnw, d, q);
    endtask : send
endmodule : lid_host
`default_nettype wire

/* File: dv/lid_decoder_checker.sv */
// assertion checker on the decoder ports
`timescale 1ns/1ps
`default_nettype none
module lid_decoder_checker
    import lid_pkg::*;
(
    input wire logic        clock,
    input wire logic        rst,
    input wire logic        strobe,
    input wire logic        reg_sel,
    input wire logic        read_not_write,
    input wire logic [7:0]  wr_data,
    input wire logic [7:0]  rd_data,
    input wire logic        busy_flag,
    input wire logic        display_on,
    input wire logic        cursor_on,
    input wire logic        blink_on,
    input wire logic        bus_width,
    input wire logic        ext_set_sel,
    input wire logic        scroll_sel,
    input wire logic        graphic_on,
    input wire logic        awake_bit,
    input wire logic        standby,
    input wire logic [3:0]  line_reversed,
    input wire logic [5:0]  scroll_offset,
    input wire logic [4:0]  shift_pos,
    input wire logic [15:0] font_row_out,
    input wire logic [5:0]  font_row_addr,
    input wire logic [15:0] cursor_pattern,
    input wire logic [15:0] char_code,
    input wire logic [15:0] icon_word,
    input wire logic [3:0]  icon_addr
);
    // ------------------------------------------------------------
    // helper logic and properties
    // ------------------------------------------------------------
    logic [CNT_W-1:0] run_reg;
    logic [CNT_W-1:0] run_next;
    logic [22:0]      flags;
    // busy run length, so the execution time can be checked exactly
    assign run_next = busy_flag ? run_reg + 16'h0001 : 16'h0000;
    assign flags = {display_on, cursor_on, blink_on, bus_width, ext_set_sel,
                    scroll_sel, graphic_on, awake_bit, line_reversed,
                    scroll_offset, shift_pos};
    always_ff @(posedge clock or posedge rst)
        if (rst)
            run_reg <= 16'h0000;
        else
            run_reg <= run_next;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    sequence s_take;
        strobe && !busy_flag && (reg_sel || !read_not_write);
    endsequence
    sequence s_status;
        strobe && !reg_sel && read_not_write;
    endsequence
    property p_busy_rise;
        s_take |=> busy_flag;
    endproperty
    property p_busy_len;
        $fell(busy_flag) |-> (run_reg == CYC_INSTR || run_reg == CYC_CLEAR);
    endproperty
    property p_status;
        s_status |=> rd_data[7] == $past(busy_flag);
    endproperty
    property p_rd_hold;
        !(strobe && read_not_write) |=> $stable(rd_data);
    endproperty
    property p_refuse;
        busy_flag |=> $stable(flags);
    endproperty
    property p_defaults;
        $past(rst) |-> flags[22:15] == 8'h11 && line_reversed == 4'h0;
    endproperty
    property p_standby_end;
        s_take ##0 standby && !reg_sel && wr_data != OP_STANDBY |=> !standby;
    endproperty
    property p_icon_gap;
        icon_addr == ICON_UNUSED |=> icon_word == 16'h0000;
    endproperty
    property p_font_cursor;
        font_row_addr[3:0] == 4'hF
            |=> (font_row_out & $past(cursor_pattern)) == $past(cursor_pattern);
    endproperty

    a_busy_rise: assert property (p_busy_rise)
        else $error("busy did not rise after a taken access");
    a_busy_len: assert property (p_busy_len)
        else $error("busy length wrong");
    a_status: assert property (p_status)
        else $error("status read lost the busy bit");
    a_rd_hold: assert property (p_rd_hold)
        else $error("read data changed without a read");
    a_refuse: assert property (p_refuse)
        else $error("mode flags changed while busy");
    a_defaults: assert property (p_defaults)
        else $error("flags not at defaults after reset");
    a_standby_end: assert property (p_standby_end)
        else $error("standby kept after an instruction");
    a_icon_gap: assert property (p_icon_gap)
        else $error("unused icon word not zero");
    a_font_cursor: assert property (p_font_cursor)
        else $error("last font row not merged with cursor");
endmodule : lid_decoder_checker
bind lid_decoder lid_decoder_checker lid_decoder_checker_i (.*);
`default_nettype wire

/* File: dv/tb.sv */
// self-checking bench of the lcd instruction decoder
`timescale 1ns/1ps
`default_nettype none
`define CHECK(act, exp) \
    begin \
        num_checks++; \
        if ((act) !== (exp)) \
        begin \
            miscompares++; \
            $display("Error at %0t: got %0h expected %0h", $time, act, exp); \
        end \
    end
module tb;
    import lid_pkg::*;
    // ------------------------------------------------------------
    // signals, instances, tasks
    // ------------------------------------------------------------
    logic        clock = 1'b0;
    logic        rst = 1'b1;
    logic        strobe, reg_sel, read_not_write, busy_flag, display_on;
    logic        cursor_on, blink_on, bus_width, ext_set_sel, scroll_sel;
    logic        graphic_on, awake_bit, standby;
    logic [7:0]  wr_data, rd_data, q;
    logic [3:0]  line_reversed;
    logic [3:0]  icon_addr = 4'h0;
    logic [5:0]  scroll_offset;
    logic [5:0]  font_row_addr = 6'h00;
    logic [4:0]  shift_pos;
    logic [15:0] font_row_out, icon_word;
    logic [15:0] cursor_pattern = 16'h0000;
    logic [15:0] char_code = 16'h0000;
    int          miscompares = 0;
    int          num_checks = 0;

    lid_decoder lid_decoder_i (.*);
    lid_host    lid_host_i (.*);

    // 25 MHz clock
    always #20 clock = ~clock;

    task automatic ins(input logic [7:0] d);
        lid_host_i.send(1'b0, 1'b0, d, q);
    endtask : ins
    task automatic wdat(input logic [7:0] d);
        lid_host_i.send(1'b1, 1'b0, d, q);
    endtask : wdat
    task automatic rdat(input logic [7:0] e);
        lid_host_i.send(1'b1, 1'b1, 8'h00, q);
        `CHECK(q, e)
    endtask : rdat
    task automatic chk_ac(input logic [6:0] e);
        lid_host_i.wait_ready();
        lid_host_i.access(1'b0, 1'b1, 8'h00, q);
        `CHECK(q, {1'b0, e})
    endtask : chk_ac
    task automatic test_done();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : test_done

    // watchdog: the sequence needs just under 100k cycles
    initial
    begin
        repeat (104000) @(posedge clock);
        miscompares++;
        test_done();
    end

    // main sequence
    initial
    begin
        repeat (12) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        `CHECK({display_on, cursor_on, blink_on, ext_set_sel}, 4'h0)
        `CHECK({scroll_sel, graphic_on, standby}, 3'h0)
        `CHECK({bus_width, awake_bit, line_reversed}, 6'h30)
        ins(8'hC5);
        lid_host_i.access(1'b0, 1'b1, 8'h00, q);
        `CHECK(q[7], 1'b1)
        lid_host_i.access(1'b0, 1'b0, 8'h0F, q);
        chk_ac(7'h05);
        `CHECK(display_on, 1'b0)
        wdat(8'h41);
        wdat(8'h42);
        chk_ac(7'h06);
        ins(8'h04);
        ins(8'h85);
        lid_host_i.send(1'b1, 1'b1, 8'h00, q);
        rdat(8'h41);
        rdat(8'h42);
        chk_ac(7'h04);
        ins(8'h02);
        chk_ac(7'h00);
        ins(8'h14);
        chk_ac(7'h01);
        ins(8'h1C);
        `CHECK(shift_pos, 5'h01)
        chk_ac(7'h01);
        ins(8'h0F);
        `CHECK({display_on, cursor_on, blink_on}, 3'h7)
        ins(8'h34);
        `CHECK(ext_set_sel, 1'b1)
        ins(8'h36);
        `CHECK({graphic_on, ext_set_sel}, 2'h3)
        ins(8'h05);
        `CHECK(line_reversed, 4'h2)
        ins(8'h05);
        `CHECK(line_reversed, 4'h0)
        ins(8'h08);
        `CHECK(awake_bit, 1'b0)
        ins(8'h0C);
        `CHECK(awake_bit, 1'b1)
        ins(8'h01);
        `CHECK(standby, 1'b1)
        ins(8'h03);
        `CHECK({standby, scroll_sel}, 2'h1)
        ins(8'h6A);
        `CHECK(scroll_offset, 6'h2A)
        ins(8'h02);
        ins(8'h43);
        wdat(8'h12);
        wdat(8'h34);
        @(posedge clock);
        icon_addr <= 4'h3;
        repeat (2) @(posedge clock);
        `CHECK(icon_word, 16'h1234)
        icon_addr <= ICON_UNUSED;
        repeat (2) @(posedge clock);
        `CHECK(icon_word, 16'h0000)
        ins(8'h30);
        ins(8'h6F);
        wdat(8'h00);
        wdat(8'h0F);
        lid_host_i.wait_ready();
        char_code      <= 16'h000D;
        font_row_addr  <= 6'h0F;
        cursor_pattern <= 16'hF000;
        repeat (2) @(posedge clock);
        `CHECK(font_row_out, 16'hF00F)
        ins(8'h01);
        ins(8'h85);
        lid_host_i.send(1'b1, 1'b1, 8'h00, q);
        rdat(SPACE_CODE);
        rdat(SPACE_CODE);
        chk_ac(7'h06);
        test_done();
    end
endmodule : tb
`default_nettype wire
